/* File: hdl/timer2_waveform_output_control.sv */
// Timer 2 counter, waveform mode decode and compare output pins behind AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module timer2_waveform_output_control #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Ordinary port logic for the two pins.
  input  wire logic              port_data_a,
  input  wire logic              port_dir_a,
  input  wire logic              port_data_b,
  input  wire logic              port_dir_b,
  // Pin drivers and interrupt.
  output var  logic              pin_a_out,
  output var  logic              pin_a_oe,
  output var  logic              pin_b_out,
  output var  logic              pin_b_oe,
  output var  logic              irq
);

  initial begin
    if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
    end
  end

  timer2_wave_pkg::state_type      state;
  timer2_wave_pkg::state_type      next_state;
  timer2_wave_pkg::wave_class_type wave_class;

  logic [2:0] mode_code;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic [7:0] top_value;
  logic       top_is_a;
  logic       tick;
  logic       at_top;
  logic       at_bottom;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       wr_go;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_strb;
  logic [7:0] rd_addr;
  logic       cnt_written;
  logic [2:0] events;
  logic [2:0] clear_mask;
  logic [1:0] match;

  assign mode_code = {state.top_bit, state.ctrl_a[timer2_wave_pkg::MODE_LO_LSB +: 2]};
  assign act_a     = state.ctrl_a[timer2_wave_pkg::ACT_A_LSB +: 2];
  assign act_b     = state.ctrl_a[timer2_wave_pkg::ACT_B_LSB +: 2];

  // Mode 2, 5 and 7 take their top from compare value A.
  assign top_is_a  = (mode_code == timer2_wave_pkg::MODE_MATCH_CLR) ||
                     (mode_code == timer2_wave_pkg::MODE_PHASE_A) ||
                     (mode_code == timer2_wave_pkg::MODE_FAST_A);
  assign top_value = top_is_a ? state.ocr[0] : timer2_wave_pkg::COUNT_MAX;

  always_comb begin
    case (mode_code)
      timer2_wave_pkg::MODE_NORMAL,
      timer2_wave_pkg::MODE_MATCH_CLR: wave_class = timer2_wave_pkg::WAVE_NON_PWM;
      timer2_wave_pkg::MODE_FAST_FF,
      timer2_wave_pkg::MODE_FAST_A:   wave_class = timer2_wave_pkg::WAVE_FAST;
      timer2_wave_pkg::MODE_PHASE_FF,
      timer2_wave_pkg::MODE_PHASE_A:  wave_class = timer2_wave_pkg::WAVE_PHASE;
      default:                        wave_class = timer2_wave_pkg::WAVE_RESERVED;
    endcase
  end

  // Bus handshakes.
  assign s_axi_awready = !state.aw_held && !state.bvalid;
  assign s_axi_wready  = !state.w_held && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign ar_hs   = s_axi_arvalid && s_axi_arready;
  assign wr_go   = (state.aw_held || aw_hs) && (state.w_held || w_hs);
  assign wr_addr = state.aw_held ? state.awaddr : {s_axi_awaddr[7:2], 2'b00};
  assign wr_data = state.w_held ? state.wdata : s_axi_wdata[7:0];
  assign wr_strb = state.w_held ? state.wstrb0 : s_axi_wstrb[0];
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  assign cnt_written = wr_go && wr_strb && (wr_addr == timer2_wave_pkg::OFF_COUNT);

  // A counter write removes the compare and overflow events of that cycle.
  assign tick      = state.run && (wave_class != timer2_wave_pkg::WAVE_RESERVED) && !cnt_written;
  assign at_top    = state.cnt == top_value;
  assign at_bottom = state.cnt == timer2_wave_pkg::COUNT_BOTTOM;
  assign match[0]  = tick && (state.cnt == state.ocr[0]);
  assign match[1]  = tick && (state.cnt == state.ocr[1]);

  always_comb begin
    events = 3'h0;
    events[timer2_wave_pkg::ST_MATCH_A] = match[0];
    events[timer2_wave_pkg::ST_MATCH_B] = match[1];
    case (wave_class)
      timer2_wave_pkg::WAVE_NON_PWM: begin
        events[timer2_wave_pkg::ST_OVF] = tick && (state.cnt == timer2_wave_pkg::COUNT_MAX);
      end
      timer2_wave_pkg::WAVE_FAST: begin
        if (mode_code == timer2_wave_pkg::MODE_FAST_A) begin
          events[timer2_wave_pkg::ST_OVF] = tick && at_top;
        end else begin
          events[timer2_wave_pkg::ST_OVF] = tick && (state.cnt == timer2_wave_pkg::COUNT_MAX);
        end
      end
      timer2_wave_pkg::WAVE_PHASE: begin
        events[timer2_wave_pkg::ST_OVF] = tick && state.down && at_bottom;
      end
      default: begin
        events[timer2_wave_pkg::ST_OVF] = 1'b0;
      end
    endcase
  end

  always_comb begin
    logic [1:0] act;
    logic       eq_top;
    logic       hit;
    logic       pwm_write;
    act       = 2'h0;
    eq_top    = 1'b0;
    hit       = 1'b0;
    pwm_write = 1'b0;
    next_state = state;
    clear_mask = 3'h0;

    // Counter sequence.
    if (cnt_written) begin
      next_state.cnt = wr_data;
    end else if (tick) begin
      case (wave_class)
        timer2_wave_pkg::WAVE_PHASE: begin
          if (!state.down) begin
            if (at_top) begin
              next_state.down = 1'b1;
              next_state.cnt  = state.cnt - timer2_wave_pkg::COUNT_STEP;
            end else begin
              next_state.cnt  = state.cnt + timer2_wave_pkg::COUNT_STEP;
            end
          end else if (at_bottom) begin
            next_state.down = 1'b0;
            next_state.cnt  = state.cnt + timer2_wave_pkg::COUNT_STEP;
          end else begin
            next_state.cnt  = state.cnt - timer2_wave_pkg::COUNT_STEP;
          end
        end
        default: begin
          next_state.cnt = at_top ? timer2_wave_pkg::COUNT_BOTTOM :
                           state.cnt + timer2_wave_pkg::COUNT_STEP;
        end
      endcase
    end
    if (wave_class != timer2_wave_pkg::WAVE_PHASE) begin
      next_state.down = 1'b0;
    end

    // Buffered compare values move to the active copies.
    if (tick && wave_class == timer2_wave_pkg::WAVE_PHASE && at_top && !state.down) begin
      next_state.ocr = state.ocr_buf;
    end
    if (tick && wave_class == timer2_wave_pkg::WAVE_FAST && at_top) begin
      next_state.ocr = state.ocr_buf;
    end

    // Output waveforms, one pass per channel.
    for (int ch = 0; ch < 2; ch++) begin
      act    = (ch == 0) ? act_a : act_b;
      eq_top = state.ocr[ch] == top_value;
      // At equality with top the match is ignored and the action is taken at top.
      hit    = (act[1] && eq_top) ? (tick && at_top) : match[ch];
      case (wave_class)
        timer2_wave_pkg::WAVE_NON_PWM: begin
          if (match[ch]) begin
            case (act)
              timer2_wave_pkg::ACT_TOGGLE: next_state.wave[ch] = !state.wave[ch];
              timer2_wave_pkg::ACT_CLEAR:  next_state.wave[ch] = 1'b0;
              timer2_wave_pkg::ACT_SET:    next_state.wave[ch] = 1'b1;
              default:                     next_state.wave[ch] = state.wave[ch];
            endcase
          end
        end
        timer2_wave_pkg::WAVE_FAST: begin
          if (act[1]) begin
            if (tick && at_bottom) begin
              next_state.wave[ch] = !act[0];
            end
            if (hit) begin
              next_state.wave[ch] = act[0];
            end
          end else if (ch == 0 && act == timer2_wave_pkg::ACT_TOGGLE && state.top_bit &&
                       match[ch]) begin
            next_state.wave[ch] = !state.wave[ch];
          end
        end
        timer2_wave_pkg::WAVE_PHASE: begin
          if (act[1]) begin
            if (hit) begin
              next_state.wave[ch] = state.down ? !act[0] : act[0];
            end
          end else if (ch == 0 && act == timer2_wave_pkg::ACT_TOGGLE && state.top_bit &&
                       match[ch]) begin
            next_state.wave[ch] = !state.wave[ch];
          end
        end
        default: begin
          next_state.wave[ch] = state.wave[ch];
        end
      endcase
    end

    // Write channel.
    if (aw_hs && !wr_go) begin
      next_state.aw_held = 1'b1;
      next_state.awaddr  = {s_axi_awaddr[7:2], 2'b00};
    end
    if (w_hs && !wr_go) begin
      next_state.w_held = 1'b1;
      next_state.wdata  = s_axi_wdata[7:0];
      next_state.wstrb0 = s_axi_wstrb[0];
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = timer2_wave_pkg::RESP_OKAY;
      pwm_write = (wave_class == timer2_wave_pkg::WAVE_FAST) ||
                  (wave_class == timer2_wave_pkg::WAVE_PHASE);
      case (wr_addr)
        timer2_wave_pkg::OFF_CTRL_A: begin
          if (wr_strb) begin
            next_state.ctrl_a = wr_data & timer2_wave_pkg::CTRL_A_RW_MASK;
          end
        end
        timer2_wave_pkg::OFF_CTRL_B: begin
          if (wr_strb) begin
            next_state.top_bit = wr_data[timer2_wave_pkg::TOP_BIT_POS];
            next_state.run     = wr_data[timer2_wave_pkg::RUN_POS];
          end
        end
        timer2_wave_pkg::OFF_CMP_A,
        timer2_wave_pkg::OFF_CMP_B: begin
          if (wr_strb) begin
            next_state.ocr_buf[wr_addr[2]] = wr_data;
            if (!pwm_write) begin
              next_state.ocr[wr_addr[2]] = wr_data;
            end
          end
        end
        timer2_wave_pkg::OFF_COUNT,
        timer2_wave_pkg::OFF_STATUS: begin
          next_state.bresp = timer2_wave_pkg::RESP_OKAY;
        end
        timer2_wave_pkg::OFF_CLEAR: begin
          if (wr_strb) begin
            clear_mask = wr_data[2:0];
          end
        end
        timer2_wave_pkg::OFF_ENABLE: begin
          if (wr_strb) begin
            next_state.enable = wr_data[2:0];
          end
        end
        default: begin
          next_state.bresp = timer2_wave_pkg::RESP_SLVERR;
        end
      endcase
    end

    // An event in the cycle of its clear keeps the flag set.
    next_state.status = (state.status & ~clear_mask) | events;

    // Read channel.
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = timer2_wave_pkg::RESP_OKAY;
      next_state.rdata  = 8'h00;
      case (rd_addr)
        timer2_wave_pkg::OFF_CTRL_A: next_state.rdata = state.ctrl_a;
        timer2_wave_pkg::OFF_CTRL_B: begin
          next_state.rdata[timer2_wave_pkg::TOP_BIT_POS] = state.top_bit;
          next_state.rdata[timer2_wave_pkg::RUN_POS]     = state.run;
        end
        timer2_wave_pkg::OFF_CMP_A:  next_state.rdata = state.ocr_buf[0];
        timer2_wave_pkg::OFF_CMP_B:  next_state.rdata = state.ocr_buf[1];
        timer2_wave_pkg::OFF_COUNT:  next_state.rdata = state.cnt;
        timer2_wave_pkg::OFF_STATUS: next_state.rdata = {5'h00, state.status};
        timer2_wave_pkg::OFF_CLEAR:  next_state.rdata = 8'h00;
        timer2_wave_pkg::OFF_ENABLE: next_state.rdata = {5'h00, state.enable};
        default:                     next_state.rresp = timer2_wave_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp  = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rresp  = state.rresp;
  assign s_axi_rdata  = {24'h000000, state.rdata};

  // A nonzero action takes the pin; the driver follows the port direction.
  assign pin_a_out = (act_a != timer2_wave_pkg::ACT_OFF) ? state.wave[0] : port_data_a;
  assign pin_a_oe  = port_dir_a;
  assign pin_b_out = (act_b != timer2_wave_pkg::ACT_OFF) ? state.wave[1] : port_data_b;
  assign pin_b_oe  = port_dir_b;
  assign irq       = |(state.status & state.enable);

  chk_pin_a_take: assert property (@(posedge mclk) disable iff (!rst_b)
    (act_a != 2'h0) |-> (pin_a_out == state.wave[0] && pin_a_oe == port_dir_a))
    else $error("output A does not hold the pin");

  chk_pin_b_take: assert property (@(posedge mclk) disable iff (!rst_b)
    (act_b != 2'h0) |-> (pin_b_out == state.wave[1] && pin_b_oe == port_dir_b))
    else $error("output B does not hold the pin");

  chk_toggle_a_plain: assert property (@(posedge mclk) disable iff (!rst_b)
    (wave_class == timer2_wave_pkg::WAVE_NON_PWM && act_a == 2'h1 && match[0])
    |=> (state.wave[0] != $past(state.wave[0])))
    else $error("output A missed its toggle");

  chk_fast_a_bottom: assert property (@(posedge mclk) disable iff (!rst_b)
    (wave_class == timer2_wave_pkg::WAVE_FAST && act_a == 2'h2 && tick && at_bottom &&
     !match[0]) |=> state.wave[0])
    else $error("fast output A not set at bottom");

  chk_phase_a_down: assert property (@(posedge mclk) disable iff (!rst_b)
    (wave_class == timer2_wave_pkg::WAVE_PHASE && act_a == 2'h2 && state.down && match[0] &&
     state.ocr[0] != top_value) |=> state.wave[0])
    else $error("phase output A not set on down match");

  chk_top_a_act: assert property (@(posedge mclk) disable iff (!rst_b)
    (wave_class == timer2_wave_pkg::WAVE_FAST && act_a == 2'h3 && tick && at_top &&
     state.ocr[0] == top_value) |=> state.wave[0])
    else $error("output A not set at top");

  chk_fast_b_reserved: assert property (@(posedge mclk) disable iff (!rst_b)
    (wave_class != timer2_wave_pkg::WAVE_NON_PWM && act_b == 2'h1 &&
     $stable(wave_class) && $stable(act_b)) |=> $stable(state.wave[1]))
    else $error("reserved B action moved the output");

  chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    state.ctrl_a[3:2] == 2'h0)
    else $error("reserved control bits not zero");

  chk_reserved_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode_code == 3'h4 || mode_code == 3'h6) && !cnt_written |=> $stable(state.cnt))
    else $error("counter ran in a reserved mode");

  chk_normal_ovf: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode_code == 3'h0 && tick && state.cnt == 8'hff)
    |=> (state.status[0] && state.cnt == 8'h00))
    else $error("normal mode overflow wrong");

  chk_phase_ovf: assert property (@(posedge mclk) disable iff (!rst_b)
    (wave_class == timer2_wave_pkg::WAVE_PHASE && tick && state.down && at_bottom)
    |=> (state.status[0] && !state.down))
    else $error("phase mode bottom flag wrong");

  chk_fast_load: assert property (@(posedge mclk) disable iff (!rst_b)
    (wave_class == timer2_wave_pkg::WAVE_FAST && tick && at_top)
    |=> (state.ocr == $past(state.ocr_buf) && state.cnt == 8'h00))
    else $error("fast mode did not load at bottom");

endmodule : timer2_waveform_output_control

`default_nettype wire

/* File: hdl/timer2_wave_pkg.sv */
// Constants, codes and state layout for the timer 2 waveform output block.
package timer2_wave_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL_A  = 8'h00;
  localparam logic [7:0] OFF_CTRL_B  = 8'h04;
  localparam logic [7:0] OFF_CMP_A   = 8'h08;
  localparam logic [7:0] OFF_CMP_B   = 8'h0c;
  localparam logic [7:0] OFF_COUNT   = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_CLEAR   = 8'h18;
  localparam logic [7:0] OFF_ENABLE  = 8'h1c;

  // Field positions.
  localparam int ACT_A_LSB   = 6;
  localparam int ACT_B_LSB   = 4;
  localparam int MODE_LO_LSB = 0;
  localparam int TOP_BIT_POS = 3;
  localparam int RUN_POS     = 0;
  localparam int ST_OVF      = 0;
  localparam int ST_MATCH_A  = 1;
  localparam int ST_MATCH_B  = 2;

  // Reset values, masks, counter limits and step.
  localparam logic [7:0] CTRL_A_RESET   = 8'h00;
  localparam logic [7:0] CTRL_A_RW_MASK = 8'hf3;
  localparam logic [7:0] CMP_RESET      = 8'h00;
  localparam logic [7:0] COUNT_RESET    = 8'h00;
  localparam logic [7:0] COUNT_MAX      = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM   = 8'h00;
  localparam logic [7:0] COUNT_STEP     = 8'h01;

  // Waveform mode codes.
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PHASE_FF = 3'h1;
  localparam logic [2:0] MODE_MATCH_CLR = 3'h2;
  localparam logic [2:0] MODE_FAST_FF  = 3'h3;
  localparam logic [2:0] MODE_PHASE_A  = 3'h5;
  localparam logic [2:0] MODE_FAST_A   = 3'h7;

  // Output action codes.
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    WAVE_NON_PWM  = 4'b0001,
    WAVE_FAST     = 4'b0010,
    WAVE_PHASE    = 4'b0100,
    WAVE_RESERVED = 4'b1000
  } wave_class_type;

  typedef struct packed {
    logic [7:0]      ctrl_a;
    logic            top_bit;
    logic            run;
    logic [1:0][7:0] ocr_buf;
    logic [1:0][7:0] ocr;
    logic [7:0]      cnt;
    logic            down;
    logic [1:0]      wave;
    logic [2:0]      status;
    logic [2:0]      enable;
    logic            aw_held;
    logic [7:0]      awaddr;
    logic            w_held;
    logic [7:0]      wdata;
    logic            wstrb0;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [7:0]      rdata;
    logic [1:0]      rresp;
  } state_type;

endpackage : timer2_wave_pkg

/* File: sim/pin_pad_model.sv */
// Pad model for the two compare output pins, with pull-ups on undriven pads.
`timescale 1ns/100ps
`default_nettype none

module pin_pad_model (
  // Driver side from the block.
  input  wire logic pin_a_out,
  input  wire logic pin_a_oe,
  input  wire logic pin_b_out,
  input  wire logic pin_b_oe,
  // Resolved pad levels.
  output wire logic pad_a,
  output wire logic pad_b
);
  // A pad that nobody drives is pulled high.
  assign pad_a = pin_a_oe ? pin_a_out : 1'b1;
  assign pad_b = pin_b_oe ? pin_b_out : 1'b1;
endmodule : pin_pad_model

`default_nettype wire

/* File: sim/timer2_waveform_output_control_tb_top.sv */
// Self-checking testbench for the timer 2 waveform output block.
`timescale 1ns/100ps
`default_nettype none

module timer2_waveform_output_control_tb_top;
  logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  resp;
  logic        pdat_a, pdir_a, pdat_b, pdir_b;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] s_rdata;
  logic        out_a, oe_a, out_b, oe_b, irq, pad_a, pad_b;
  logic [31:0] hi_a, hi_b, tr_a, tr_b;
  int          num_errors, total_checks;

  timer2_waveform_output_control timer2_waveform_output_control_inst (
    .mclk(mclk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(s_rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_data_a(pdat_a), .port_dir_a(pdir_a), .port_data_b(pdat_b), .port_dir_b(pdir_b),
    .pin_a_out(out_a), .pin_a_oe(oe_a), .pin_b_out(out_b), .pin_b_oe(oe_b), .irq(irq)
  );

  pin_pad_model pin_pad_model_inst (
    .pin_a_out(out_a), .pin_a_oe(oe_a), .pin_b_out(out_b), .pin_b_oe(oe_b),
    .pad_a(pad_a), .pad_b(pad_b)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_go, w_go, b_go;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    b_go = 1'b0;
    while (!b_go) begin
      @(negedge mclk);
      aw_go = awvalid && awready; w_go = wvalid && wready; b_go = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ar_go, r_go;
    araddr <= a; arvalid <= 1'b1;
    r_go = 1'b0;
    while (!r_go) begin
      @(negedge mclk);
      ar_go = arvalid && arready; r_go = rvalid;
      rdata = s_rdata; resp = rresp;
      @(posedge mclk);
      if (ar_go) arvalid <= 1'b0;
    end
  endtask : rd

  // Lets the waveform settle for n cycles, then counts high cycles and edges over n more.
  task automatic meas(input int n);
    logic pa, pb;
    repeat (n) @(posedge mclk);
    // The starting level is taken where it is settled, away from the edge.
    @(negedge mclk);
    hi_a = '0; hi_b = '0; tr_a = '0; tr_b = '0; pa = pad_a; pb = pad_b;
    repeat (n) begin
      @(negedge mclk);
      hi_a = hi_a + pad_a; hi_b = hi_b + pad_b;
      tr_a = tr_a + (pad_a ^ pa); tr_b = tr_b + (pad_b ^ pb);
      pa = pad_a; pb = pad_b;
    end
    @(posedge mclk);
  endtask : meas

  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  initial begin
    #(25ns * 30000);
    num_errors++;
    results();
  end

  initial begin
    // Both response channels are always accepted, so ready never flips between transfers.
    rst_b = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1; arvalid = 1'b0; rready = 1'b1;
    awaddr = '0; araddr = '0; wdata = '0; pdat_a = 1'b1; pdir_a = 1'b0; pdat_b = 1'b0;
    pdir_b = 1'b1;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd(timer2_wave_pkg::OFF_CTRL_A); check(rdata, 32'h00, "ctrl reset");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'hff);
    rd(timer2_wave_pkg::OFF_CTRL_A); check(rdata, 32'hf3, "ctrl reserved");
    rd(8'h24); check({30'h0, resp}, 32'h2, "unmapped resp");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h00);
    check({31'h0, pad_a}, 32'h1, "undriven pad");
    check({31'h0, out_b}, {31'h0, pdat_b}, "port owns pin");
    pdir_a <= 1'b1; pdat_a <= 1'b0; pdat_b <= 1'b1;
    $display("test registers done");
    wr(timer2_wave_pkg::OFF_CMP_A, 32'h40);
    wr(timer2_wave_pkg::OFF_CMP_B, 32'h80);
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'hf0);
    wr(timer2_wave_pkg::OFF_CTRL_B, 32'h01);
    meas(256); check(hi_a, 32'd256, "set a"); check(hi_b, 32'd256, "set b");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'ha0);
    meas(256); check(hi_a, 32'd0, "clear a"); check(hi_b, 32'd0, "clear b");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h50);
    meas(256); check(tr_a, 32'd1, "tog a"); check(tr_b, 32'd1, "tog b");
    wr(timer2_wave_pkg::OFF_CMP_A, 32'h3f);
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h42);
    wr(timer2_wave_pkg::OFF_COUNT, 32'h00);
    meas(128); check(tr_a, 32'd2, "match top");
    $display("test non-pwm done");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h00);
    wr(timer2_wave_pkg::OFF_CMP_A, 32'h40);
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'hb3);
    meas(256); check(hi_a, 32'd64, "fast a"); check(hi_b, 32'd128, "fast b");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'hb1);
    meas(510); check(hi_a, 32'd128, "phase a"); check(hi_b, 32'd254, "phase b");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h00);
    wr(timer2_wave_pkg::OFF_CMP_A, 32'h3f);
    wr(timer2_wave_pkg::OFF_CMP_B, 32'h10);
    wr(timer2_wave_pkg::OFF_CTRL_B, 32'h09);
    wr(timer2_wave_pkg::OFF_COUNT, 32'h00);
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h93);
    meas(64); check(hi_a, 32'd63, "a at top"); check(tr_b, 32'd0, "b reserved");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h63);
    meas(128); check(tr_a, 32'd2, "tog top"); check(hi_b, 32'd32, "fast top b");
    wr(timer2_wave_pkg::OFF_CMP_B, 32'h3f);
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h21);
    meas(126); check(hi_b, 32'd0, "b at top");
    $display("test pwm done");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h00);
    wr(timer2_wave_pkg::OFF_CTRL_B, 32'h01);
    wr(timer2_wave_pkg::OFF_CLEAR, 32'h07);
    wr(timer2_wave_pkg::OFF_ENABLE, 32'h01);
    check({31'h0, irq}, 32'h0, "irq clear");
    repeat (300) @(posedge mclk);
    check({31'h0, irq}, 32'h1, "irq at max");
    wr(timer2_wave_pkg::OFF_CTRL_B, 32'h00);
    wr(timer2_wave_pkg::OFF_CLEAR, 32'h01);
    rd(timer2_wave_pkg::OFF_STATUS); check(rdata & 32'h1, 32'h0, "flag cleared");
    check({31'h0, irq}, 32'h0, "irq dropped");
    $display("test overflow done");
    wr(timer2_wave_pkg::OFF_COUNT, 32'h05);
    wr(timer2_wave_pkg::OFF_CTRL_B, 32'h09);
    repeat (20) @(posedge mclk);
    rd(timer2_wave_pkg::OFF_COUNT); check(rdata, 32'h05, "mode 4 holds");
    wr(timer2_wave_pkg::OFF_CTRL_A, 32'h02);
    repeat (20) @(posedge mclk);
    rd(timer2_wave_pkg::OFF_COUNT); check(rdata, 32'h05, "mode 6 holds");
    $display("test reserved modes done");
    results();
  end
endmodule : timer2_waveform_output_control_tb_top

`default_nettype wire
